// File: design/sisa_pkg.sv
`default_nettype none

package sisa_pkg;

   // interrupt slots carried by the agent: irq 1 .. irq 15
   localparam int unsigned NUM_IRQ = 15;

   typedef logic [NUM_IRQ:1] sisa_vec_t;

   // sampling periods: period n is sampled 3n-1 clocks past the start rise
   localparam logic [4:0] FIRST_IRQ_PERIOD = 5'h02;
   localparam logic [4:0] LAST_IRQ_PERIOD  = 5'h10;
   localparam logic [4:0] PERIOD_TO_SLOT   = 5'h01;

   // stop frame low widths, in clocks
   localparam logic [3:0] STOP_QUIET_WIDTH = 4'h2;
   localparam logic [3:0] STOP_CONT_WIDTH  = 4'h3;
   localparam logic [3:0] LOW_WIDTH_MAX    = 4'hf;

   // clock number, counted from the stop rise, at which a start may begin
   localparam logic [1:0] START_GAP_CLKS   = 2'h2;
   // clock number the agent is in once it has seen a rising edge
   localparam logic [1:0] RISE_SEEN_CLK    = 2'h1;

   // reset puts every slave in continuous mode
   localparam logic       QUIET_RST        = 1'b0;

   typedef enum logic [1:0] {
      CYC_IDLE,
      CYC_START,
      CYC_FRAMES,
      CYC_STOPWAIT
   } sisa_cyc_t;

   typedef enum logic [1:0] {
      PH_SAMPLE,
      PH_RECOVER,
      PH_TURN
   } sisa_phase_t;

   typedef struct packed {
      sisa_cyc_t   st;
      sisa_phase_t ph;
      logic [4:0]  period;
      logic [1:0]  since;
      logic        drove;
      logic        quiet;
      logic        oe;
      logic        out;
      logic        active;
      logic        pend;
      sisa_vec_t   lvl;
      sisa_vec_t   sent;
   } sisa_state_t;

   localparam sisa_state_t STATE_RST = '{
      st:     CYC_IDLE,
      ph:     PH_TURN,
      period: 5'h00,
      since:  START_GAP_CLKS,
      drove:  1'b0,
      quiet:  QUIET_RST,
      oe:     1'b0,
      out:    1'b1,
      active: 1'b0,
      pend:   1'b0,
      lvl:    '1,
      sent:   '1
   };

   typedef struct packed {
      logic       prev;
      logic [3:0] low_cnt;
   } sisa_meas_t;

   localparam sisa_meas_t MEAS_RST = '{prev: 1'b1, low_cnt: 4'h0};

   typedef struct packed {
      logic cycle_active;
      logic quiet_mode;
      logic change_pending;
   } sisa_status_t;

endpackage

`default_nettype wire

// File: design/sisa_low_meas.sv
`default_nettype none

// counts consecutive low clocks of the shared line and flags the rise that
// ends a low pulse, together with the pulse's width
module sisa_low_meas (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       line_in,
   output logic            rise,
   output logic [3:0]      width
);

   sisa_pkg::sisa_meas_t m_q;
   sisa_pkg::sisa_meas_t m_d;

   always_comb begin
      m_d = m_q;
      m_d.prev = line_in;
      if (!line_in) begin
         // saturate so an over-long pulse never wraps into a legal width
         if (m_q.low_cnt != sisa_pkg::LOW_WIDTH_MAX) begin
            m_d.low_cnt = m_q.low_cnt + 4'h1;
         end
      end else begin
         m_d.low_cnt = 4'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         m_q <= sisa_pkg::MEAS_RST;
      end else begin
         m_q <= m_d;
      end
   end

   assign rise  = line_in & ~m_q.prev;
   assign width = m_q.low_cnt;

endmodule

`default_nettype wire

// File: design/sisa_agent.sv
`default_nettype none

// Function
// RULE_01: in quiet mode, idle line, start frame is one low clock, then release
// RULE_02: never begin a start frame between a start frame and its stop frame
// RULE_03: host extends the start pulse to 4-8 low clocks, then drives high
// RULE_04: quiet mode: a level change not deliverable in this cycle starts a frame
// RULE_05: continuous mode: agent stays passive, never starts a frame
// RULE_06: stop frame low width sets next mode; mode changes only there
// RULE_07: data frames are counted from the rise ending the start pulse
// RULE_08: each data frame is sample, recovery and turn-around clocks
// RULE_09: sample phase of owned slot: drive low only if level low
// RULE_10: recovery phase: drive high only if low was driven just before
// RULE_11: turn-around phase: always release the line
// RULE_12: report low level whoever started the cycle
// RULE_13: period n sampled 3n-1 clocks after start rise; irq k is period k+1
// RULE_14: irq 13 travels in period 14
// RULE_15: host ends the cycle: stop low 2 clocks quiet, 3 continuous
// RULE_16: quiet start no earlier than second clock after stop rise
// RULE_17: line driven and sampled only on rising clock edges
// RULE_18: reset releases the line and selects continuous mode
// RULE_19: host runs first cycle after reset to collect default levels
// RULE_20: host delays end-of-interrupt and in-service reads by cycle latency
// RULE_21: host selects continuous mode before suspend or agent changes
// RULE_22: one latched level per slot; unowned slots stay released
module sisa_agent (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  sirq_in,
   output logic                       sirq_out,
   output logic                       sirq_oe,
   input  wire sisa_pkg::sisa_vec_t   irq_level,
   input  wire sisa_pkg::sisa_vec_t   irq_own,
   output sisa_pkg::sisa_status_t     status
);

   sisa_pkg::sisa_state_t s_q;
   sisa_pkg::sisa_state_t s_d;

   logic       line_rise;
   logic [3:0] low_width;
   logic [4:0] slot;
   logic [1:0] since_nx;

   sisa_low_meas sisa_low_meas_i (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .line_in (sirq_in),
      .rise    (line_rise),
      .width   (low_width)
   );

   always_comb begin
      s_d = s_q;
      slot = 5'h00;
      since_nx = s_q.since;

      // the level is refreshed every clock; what a slot carried is kept in
      // sent, so a change after its slot is remembered for the next cycle
      s_d.lvl = irq_level; // RULE_22

      // line released unless a phase below claims it
      s_d.oe = 1'b0; // RULE_11 RULE_01
      s_d.out = 1'b1;

      unique case (s_q.st)
         sisa_pkg::CYC_IDLE: begin
            if (s_q.since != sisa_pkg::START_GAP_CLKS) begin
               since_nx = s_q.since + 2'h1;
            end
            s_d.since = since_nx;
            if (!sirq_in) begin
               // anyone, host or agent, pulling low opens a cycle
               s_d.st = sisa_pkg::CYC_START; // RULE_12
            end else if (s_q.quiet && s_q.pend && !s_q.oe && // RULE_04 RULE_05
                         since_nx == sisa_pkg::START_GAP_CLKS) begin // RULE_16
               // one low clock only; next edge falls into the default release
               s_d.oe = 1'b1; // RULE_01 RULE_02
               s_d.out = 1'b0;
            end
         end

         sisa_pkg::CYC_START: begin
            if (line_rise) begin
               // rise seen: this clock is the start frame's turn-around
               s_d.st = sisa_pkg::CYC_FRAMES; // RULE_07
               s_d.ph = sisa_pkg::PH_TURN;
               s_d.period = 5'h00;
               s_d.drove = 1'b0;
            end
         end

         sisa_pkg::CYC_FRAMES: begin
            unique case (s_q.ph)
               sisa_pkg::PH_TURN: begin
                  if (s_q.period == sisa_pkg::LAST_IRQ_PERIOD) begin
                     s_d.st = sisa_pkg::CYC_STOPWAIT;
                  end else begin
                     // sample clock of period n lands on clock 3n-1
                     s_d.ph = sisa_pkg::PH_SAMPLE; // RULE_08 RULE_13
                     s_d.period = s_q.period + 5'h01;
                     slot = s_d.period - sisa_pkg::PERIOD_TO_SLOT; // RULE_14
                     if (s_d.period >= sisa_pkg::FIRST_IRQ_PERIOD &&
                         irq_own[slot[3:0]]) begin // RULE_22
                        s_d.sent[slot[3:0]] = s_q.lvl[slot[3:0]];
                        if (!s_q.lvl[slot[3:0]]) begin
                           s_d.oe = 1'b1; // RULE_09 RULE_12
                           s_d.out = 1'b0;
                           s_d.drove = 1'b1;
                        end
                     end
                  end
               end
               sisa_pkg::PH_SAMPLE: begin
                  s_d.ph = sisa_pkg::PH_RECOVER; // RULE_08
                  if (s_q.drove) begin
                     // a short high drive speeds the pull-up's recovery
                     s_d.oe = 1'b1; // RULE_10
                     s_d.out = 1'b1;
                  end
               end
               sisa_pkg::PH_RECOVER: begin
                  s_d.ph = sisa_pkg::PH_TURN; // RULE_08 RULE_11
                  s_d.drove = 1'b0;
               end
               default: begin
                  s_d.ph = sisa_pkg::PH_TURN;
               end
            endcase
         end

         sisa_pkg::CYC_STOPWAIT: begin
            // one-clock lows are further data frames; only 2 or 3 is a stop
            if (line_rise) begin
               if (low_width == sisa_pkg::STOP_QUIET_WIDTH) begin
                  s_d.quiet = 1'b1; // RULE_06 RULE_15
                  s_d.st = sisa_pkg::CYC_IDLE;
                  s_d.since = sisa_pkg::RISE_SEEN_CLK;
               end else if (low_width == sisa_pkg::STOP_CONT_WIDTH) begin
                  s_d.quiet = 1'b0; // RULE_06 RULE_15
                  s_d.st = sisa_pkg::CYC_IDLE;
                  s_d.since = sisa_pkg::RISE_SEEN_CLK;
               end
            end
         end
      endcase

      s_d.active = (s_d.st != sisa_pkg::CYC_IDLE);
      s_d.pend = |((s_q.lvl ^ s_d.sent) & irq_own); // RULE_04
   end

   // all drive and sampling happen on the rising edge only
   always_ff @(posedge clk_sys or negedge rst_n) begin // RULE_17
      if (!rst_n) begin
         s_q <= sisa_pkg::STATE_RST; // RULE_18
      end else begin
         s_q <= s_d;
      end
   end

   assign sirq_out = s_q.out;
   assign sirq_oe = s_q.oe;
   // one driver for the whole status word, every field straight from s_q
   assign status = '{
      cycle_active:   s_q.active,
      quiet_mode:     s_q.quiet,
      change_pending: s_q.pend
   };

endmodule

`default_nettype wire

// File: test/sisa_agent_assertions.sv
`default_nettype none
module sisa_agent_assertions (
   input wire logic                   clk_sys,
   input wire logic                   rst_n,
   input wire logic                   sirq_in,
   input wire logic                   sirq_out,
   input wire logic                   sirq_oe,
   input wire sisa_pkg::sisa_vec_t    irq_level,
   input wire sisa_pkg::sisa_vec_t    irq_own,
   input wire sisa_pkg::sisa_status_t status
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire logic drv_low = sirq_oe && !sirq_out;
   a_low_one_clk: assert property (drv_low |=> !drv_low)
      else $error("low drive longer than one clock");
   a_start_no_high: assert property (drv_low && !status.cycle_active |=> !sirq_oe)
      else $error("start pulse not released");
   a_recover_after_low: assert property (sirq_oe && sirq_out |-> $past(drv_low))
      else $error("high drive without low before");
   a_turn_release: assert property (sirq_oe && sirq_out |=> !sirq_oe)
      else $error("line held past recovery");
   a_low_after_idle: assert property (drv_low |-> $past(sirq_in) && $past(sirq_in, 2))
      else $error("low drive too close to low line");
   a_cont_passive: assert property (!status.quiet_mode && !status.cycle_active |-> !sirq_oe)
      else $error("drive while passive");
   a_mode_at_stop: assert property ($changed(status.quiet_mode) |-> !status.cycle_active)
      else $error("mode changed inside a cycle");
   a_reset_idle: assert property (disable iff (1'b0) !rst_n |-> !sirq_oe && !status.quiet_mode)
      else $error("line or mode wrong in reset");
   cover property ($rose(status.change_pending));
   cover property ($rose(status.quiet_mode));
   cover property (sirq_oe && sirq_out);
endmodule
`default_nettype wire

// File: test/sisa_host_model.sv
`default_nettype none
module sisa_host_model (
   input  wire logic          clk_sys,
   input  wire logic          line,
   input  wire logic          go,
   input  wire logic [3:0]    stop_w,
   output var logic           oe,
   output var logic           out,
   output var logic           busy,
   output var sisa_pkg::sisa_vec_t seen
);
   timeunit 1ns;
   timeprecision 1ns;
   sisa_pkg::sisa_vec_t got;
   // all drives land just after a rising edge; the line is read at the edge
   initial begin
      oe = 1'b0;
      out = 1'b1;
      busy = 1'b0;
      seen = '1;
      got = '1;
      forever begin
         @(posedge clk_sys);
         if (go || !line) begin
            busy <= 1'b1;
            oe <= 1'b1;
            out <= 1'b0;
            // an agent start already gave one low clock, so the total stays four
            repeat (line ? 4 : 3) @(posedge clk_sys);
            out <= 1'b1;
            @(posedge clk_sys);
            oe <= 1'b0;
            for (int c = 1; c < 50; c++) begin
               @(posedge clk_sys);
               if (c % 3 == 2 && c > 4) got[c / 3] = line;
            end
            oe <= 1'b1;
            out <= 1'b0;
            repeat (stop_w) @(posedge clk_sys);
            out <= 1'b1;
            @(posedge clk_sys);
            oe <= 1'b0;
            // levels are published only once the whole cycle is in, the latency
            // a host must allow before acting on them
            seen <= got;
            busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: test/sisa_agent_bench.sv
`default_nettype none
module sisa_agent_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                   clk_sys = 1'b0;
   logic                   rst_n = 1'b1;
   logic                   go = 1'b0;
   logic [3:0]             stop_w = 4'h3;
   sisa_pkg::sisa_vec_t    lvl = 15'h0aa5;
   sisa_pkg::sisa_vec_t    own = 15'h7eff;
   sisa_pkg::sisa_vec_t    seen;
   sisa_pkg::sisa_status_t st;
   logic                   a_oe, a_out, h_oe, h_out, busy;
   int                     n_fail = 0;
   int                     cmp_count = 0;
   // released line is pulled high
   wire logic              line = !((a_oe && !a_out) || (h_oe && !h_out));
   always #20 clk_sys = ~clk_sys;
   sisa_agent sisa_agent_i (.clk_sys(clk_sys), .rst_n(rst_n), .sirq_in(line), .sirq_out(a_out),
      .sirq_oe(a_oe), .irq_level(lvl), .irq_own(own), .status(st));
   sisa_host_model sisa_host_model_i (.clk_sys(clk_sys), .line(line), .go(go), .stop_w(stop_w),
      .oe(h_oe), .out(h_out), .busy(busy), .seen(seen));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wait_busy(input logic v, input int n);
      for (int i = 0; i < n && busy !== v; i++) @(negedge clk_sys);
   endtask
   task automatic cyc(input logic [3:0] w);
      stop_w = w;
      go = 1'b1;
      wait_busy(1'b1, 20);
      go = 1'b0;
      wait_busy(1'b0, 200);
      check({15'h0, busy}, 16'h0);
      check({15'h0, st.cycle_active}, 16'h0);
   endtask
   task automatic t_reset;
      check({13'h0, a_oe, st.quiet_mode, st.change_pending}, 16'h0);
   endtask
   task automatic t_slots;
      cyc(4'h3);
      check({1'b0, seen}, {1'b0, lvl | ~own});
      check({15'h0, seen[13]}, 16'h0);
      check({14'h0, st.quiet_mode, st.change_pending}, 16'h0);
   endtask
   task automatic t_cont;
      lvl[3] = 1'b0;
      repeat (30) @(negedge clk_sys);
      check({15'h0, busy}, 16'h0);
      check({15'h0, st.change_pending}, 16'h1);
      cyc(4'h2);
      check({1'b0, seen}, {1'b0, lvl | ~own});
      check({14'h0, st.quiet_mode, st.change_pending}, 16'h2);
   endtask
   task automatic t_quiet;
      lvl[1] = 1'b0;
      wait_busy(1'b1, 80);
      check({15'h0, busy}, 16'h1);
      check({15'h0, st.cycle_active}, 16'h1);
      wait_busy(1'b0, 200);
      check({1'b0, seen}, {1'b0, lvl | ~own});
      check({15'h0, st.quiet_mode}, 16'h1);
      cyc(4'h3);
      check({15'h0, st.quiet_mode}, 16'h0);
   endtask
   initial begin
      // an initialiser raises no event, so reset is entered by a real fall
      #1 rst_n = 1'b0;
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      t_reset();
      t_slots();
      t_cont();
      t_quiet();
      finish_test();
   end
   initial begin
      #100000;
      n_fail++;
      finish_test();
   end
endmodule
bind sisa_agent sisa_agent_assertions sisa_agent_assertions_i (.clk_sys(clk_sys),
   .rst_n(rst_n), .sirq_in(sirq_in), .sirq_out(sirq_out), .sirq_oe(sirq_oe),
   .irq_level(irq_level), .irq_own(irq_own), .status(status));
`default_nettype wire
